// file: bench/psh_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural pseudo-static memory that answers the host port's pins.
module psh_dev_model #(
  parameter int ACC_NS = 60
) (
  input  wire logic        clk,
  input  wire logic [19:0] mem_addr,
  input  wire logic        chip_select_n,
  input  wire logic        chip_select_hi,
  input  wire logic        write_strobe_n,
  input  wire logic        output_gate_n,
  input  wire logic        upper_lane_enable_n,
  input  wire logic        lower_lane_enable_n,
  input  wire logic [15:0] data_bus_out,
  output logic [15:0]      data_bus_in
);
  logic [15:0] mem [0:(1<<20)-1];
  logic [15:0] noise = 16'hA5C3;
  logic [15:0] word_d;
  logic [15:0] lat_d;
  logic [1:0]  lat_l;
  logic [19:0] lat_a;
  logic        sel;
  logic        wr_act;
  logic        rd_lo;
  logic        rd_hi;
  // Selection needs both selects and at least one lane; otherwise the lanes show the flipping pattern.
  assign sel = !chip_select_n && chip_select_hi && !(upper_lane_enable_n && lower_lane_enable_n);
  assign wr_act = sel && !write_strobe_n;
  assign rd_lo = sel && write_strobe_n && !output_gate_n && !lower_lane_enable_n;
  assign rd_hi = sel && write_strobe_n && !output_gate_n && !upper_lane_enable_n;
  // Stored data appears only after the access time, old data lingers meanwhile.
  assign #(ACC_NS) word_d = mem[mem_addr];
  // A released lane shows a pattern that flips every cycle, never the last value.
  assign data_bus_in = {rd_hi ? word_d[15:8] : noise[15:8], rd_lo ? word_d[7:0] : noise[7:0]};
  always @(posedge clk) begin
    noise <= ~noise;
  end
  // Bus, lanes and address are followed while the write is open.
  always @* begin
    if (wr_act) begin
      lat_d = data_bus_out;
      lat_l = {upper_lane_enable_n, lower_lane_enable_n};
      lat_a = mem_addr;
    end
  end
  // The write lands when its interval closes, lane by lane.
  always @(negedge wr_act) begin
    if (!lat_l[0]) mem[lat_a][7:0] = lat_d[7:0];
    if (!lat_l[1]) mem[lat_a][15:8] = lat_d[15:8];
  end
endmodule // psh_dev_model
`default_nettype wire

// file: bench/test_psh_host.sv
`timescale 1ns/1ps
`default_nettype none
// Random and corner traffic through the host port into the memory model.
module test_psh_host;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, data_bus_oe;
  logic [19:0] req_addr = 20'h00000, mem_addr;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, data_bus_in, data_bus_out;
  logic [1:0] req_lane_n = 2'h3;
  logic cs_n, cs_hi, we_n, gate_n, up_n, lo_n;
  logic [15:0] ref_mem [logic [19:0]];
  int error_cnt = 0, checked = 0, seed, i;
  logic [31:0] r;
  psh_host i_psh_host (.clk(clk), .resetn(resetn), .ce(ce), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_lane_n(req_lane_n), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .chip_select_n(cs_n),
    .chip_select_hi(cs_hi), .write_strobe_n(we_n), .output_gate_n(gate_n), .upper_lane_enable_n(up_n),
    .lower_lane_enable_n(lo_n), .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
  psh_dev_model i_psh_dev_model (.clk(clk), .mem_addr(mem_addr), .chip_select_n(cs_n), .chip_select_hi(cs_hi),
    .write_strobe_n(we_n), .output_gate_n(gate_n), .upper_lane_enable_n(up_n), .lower_lane_enable_n(lo_n),
    .data_bus_out(data_bus_out), .data_bus_in(data_bus_in));
  // Clock of 8 ns period.
  initial begin
    forever #4 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // Expected read word: disabled lanes come back as zero.
  function automatic logic [15:0] exp_rd(input logic [19:0] a, input logic [1:0] ln);
    return {ln[1] ? 8'h00 : ref_mem[a][15:8], ln[0] ? 8'h00 : ref_mem[a][7:0]};
  endfunction
  // Cycles from take to response: pulse and recovery for a write; access, three sync stages and hold for a read.
  function automatic int exp_lat(input logic wr);
    return wr ? psh_pkg::WCYC + 1 : psh_pkg::SAMPLE_CYC + 4;
  endfunction
  // One request: wait for the take, then for the response under a bound.
  task automatic op(input logic wr, input logic [19:0] a, input logic [15:0] d, input logic [1:0] ln);
    int n;
    logic [15:0] w;
    req_valid <= 1'b1; req_write <= wr; req_addr <= a; req_wdata <= d; req_lane_n <= ln;
    n = 0;
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    if (n >= 50) begin error_cnt++; summarize(); end
    n = 0;
    do begin @(posedge clk); #1; n++; end while (rsp_valid !== 1'b1 && n < 40);
    check("response latency", n, exp_lat(wr));
    if (n >= 40) summarize();
    if (!wr) check("read data", rsp_rdata, exp_rd(a, ln));
    else begin
      w = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
      if (!ln[0]) w[7:0] = d[7:0];
      if (!ln[1]) w[15:8] = d[15:8];
      ref_mem[a] = w;
    end
  endtask
  // The host may only drive the bus while the output gate is closed.
  always @(posedge clk) begin
    if (resetn && data_bus_oe === 1'b1) check("gate while driving", gate_n, 1);
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    seed = 83;
    repeat (12) @(posedge clk);
    check("select in reset", {cs_n, cs_hi, we_n, data_bus_oe}, 32'h0000000A);
    resetn <= 1'b1;
    @(posedge clk); #1;
    for (i = 0; i < 16; i++) op(1'b1, 20'(i), 16'($random(seed)), 2'h0);
    op(1'b1, 20'hFFFFF, 16'hBEEF, 2'h0);
    op(1'b0, 20'hFFFFF, 16'h0000, 2'h0);
    // Let the turnaround after the read pass before the next request.
    i = 0;
    while (req_ready !== 1'b1 && i < 20) begin @(posedge clk); #1; i++; end
    // Both lanes disabled: dropped, no select, no response.
    req_valid <= 1'b1; req_write <= 1'b1; req_lane_n <= 2'h3;
    repeat (20) begin
      @(posedge clk); #1;
      check("dropped request", {rsp_valid, cs_n, req_ready}, 32'h3);
    end
    // Enable low: a valid request with lanes open must not be taken.
    ce <= 1'b0; req_lane_n <= 2'h0;
    repeat (8) begin
      @(posedge clk); #1;
      check("frozen by enable", {rsp_valid, cs_n, req_ready}, 32'h3);
    end
    ce <= 1'b1;
    op(1'b1, 20'h00005, 16'h1234, 2'h0);
    for (i = 0; i < 80; i++) begin
      r = $random(seed);
      op(r[0], (r[7:1] == 7'h7F) ? 20'hFFFFF : {16'h0000, r[4:1]}, r[31:16], (r[6:5] == 2'h3) ? 2'h0 : r[6:5]);
    end
    summarize();
  end
endmodule // test_psh_host
`default_nettype wire

// file: hw/psh_host.sv
`timescale 1ns/1ps
`default_nettype none
module psh_host #(
  parameter int ADDR_W = psh_pkg::ADDR_W,
  parameter int DATA_W = psh_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lane_n,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   chip_select_n,
  output logic                   chip_select_hi,
  output logic                   write_strobe_n,
  output logic                   output_gate_n,
  output logic                   upper_lane_enable_n,
  output logic                   lower_lane_enable_n,
  input  wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0]      data_bus_out,
  output logic                   data_bus_oe
);
  localparam logic [psh_pkg::CNT_W-1:0] READ_LAST = psh_pkg::CNT_W'(psh_pkg::READ_CYC - 1);
  localparam logic [psh_pkg::CNT_W-1:0] SAMPLE_AT = psh_pkg::CNT_W'(psh_pkg::SAMPLE_CYC - 1);
  localparam logic [psh_pkg::CNT_W-1:0] WP_LAST = psh_pkg::CNT_W'(psh_pkg::WPULSE_CYC - 1);
  localparam logic [psh_pkg::CNT_W-1:0] WREC_LAST =
    psh_pkg::CNT_W'(psh_pkg::WCYC - psh_pkg::WPULSE_CYC);
  localparam logic [psh_pkg::CNT_W-1:0] TURN_LAST = psh_pkg::CNT_W'(psh_pkg::TURN_CYC - 1);

  initial begin
    if (ADDR_W != 20 || DATA_W != 16)
      $error("psh_host serves a 20-bit address and 16-bit data only");
    if (psh_pkg::READ_CYC >= 32 || psh_pkg::WCYC >= 32)
      $error("psh_host counter too narrow");
  end

  typedef enum logic [2:0] {PSH_IDLE, PSH_READ, PSH_WPULSE, PSH_WREC, PSH_TURN} psh_state_e;

  psh_state_e                 state, next_state;
  logic [psh_pkg::CNT_W-1:0]  cnt, next_cnt;
  logic [ADDR_W-1:0]          next_mem_addr;
  logic                       next_cs_n, next_cs_hi, next_we_n, next_oe_n, next_ub_n, next_lb_n;
  logic [DATA_W-1:0]          next_dout, next_rdata;
  logic                       next_doe, next_ready, next_rsp;
  logic [DATA_W-1:0]          din_s1, din_s2, din_s3;

  // Data pins cross from outside; three stages, value taken from the last stage.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
      din_s3 <= 16'h0000;
    end else if (ce) begin
      din_s1 <= data_bus_in;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
    end
  end

  // Sequencer for the pin strobes.
  always_comb begin
    next_state    = state;
    next_cnt      = cnt + 5'h01;
    next_mem_addr = mem_addr;
    next_cs_n     = chip_select_n;
    next_cs_hi    = chip_select_hi;
    next_we_n     = write_strobe_n;
    next_oe_n     = output_gate_n;
    next_ub_n     = upper_lane_enable_n;
    next_lb_n     = lower_lane_enable_n;
    next_dout     = data_bus_out;
    next_doe      = data_bus_oe;
    next_rdata    = rsp_rdata;
    next_rsp      = 1'b0;
    next_ready    = 1'b0;
    unique case (state)
      PSH_IDLE: begin
        next_ready = 1'b1;
        next_cnt   = 5'h00;
        if (req_valid && req_ready && req_lane_n != 2'h3) begin
          next_ready    = 1'b0;
          next_mem_addr = req_addr;
          next_cs_n     = 1'b0;
          next_cs_hi    = 1'b1;
          next_ub_n     = req_lane_n[1];
          next_lb_n     = req_lane_n[0];
          if (req_write) begin
            // Strobe, select and lanes open together; data is driven for the whole pulse.
            next_we_n  = 1'b0;
            next_oe_n  = 1'b1;
            next_dout  = req_wdata;
            next_doe   = 1'b1;
            next_state = PSH_WPULSE;
          end else begin
            next_we_n  = 1'b1;
            next_oe_n  = 1'b0;
            next_doe   = 1'b0;
            next_state = PSH_READ;
          end
        end
      end
      PSH_READ: begin
        // Sample once the bus value taken after the access time has cleared all three stages.
        // Lanes not enabled read as zero.
        if (cnt == SAMPLE_AT + 5'h03) begin
          next_rdata = {upper_lane_enable_n ? 8'h00 : din_s3[15:8],
                        lower_lane_enable_n ? 8'h00 : din_s3[7:0]};
        end
        if (cnt >= READ_LAST && cnt >= SAMPLE_AT + 5'h04) begin
          next_rsp   = 1'b1;
          next_oe_n  = 1'b1;
          next_cs_n  = 1'b1;
          next_cs_hi = 1'b0;
          next_ub_n  = 1'b1;
          next_lb_n  = 1'b1;
          next_cnt   = 5'h00;
          next_state = PSH_TURN;
        end
      end
      PSH_WPULSE: begin
        if (cnt == WP_LAST) begin
          // Strobe and select end together; data stays one more cycle, the address until the next request.
          next_we_n  = 1'b1;
          next_cs_n  = 1'b1;
          next_cs_hi = 1'b0;
          next_ub_n  = 1'b1;
          next_lb_n  = 1'b1;
          next_cnt   = 5'h00;
          next_state = PSH_WREC;
        end
      end
      PSH_WREC: begin
        next_doe = 1'b0;
        if (cnt >= WREC_LAST) begin
          next_rsp   = 1'b1;
          next_cnt   = 5'h00;
          next_state = PSH_IDLE;
        end
      end
      PSH_TURN: begin
        if (cnt >= TURN_LAST) begin
          next_cnt   = 5'h00;
          next_state = PSH_IDLE;
        end
      end
    endcase
  end

  // Registers every output of the sequencer.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state               <= PSH_IDLE;
      cnt                 <= 5'h00;
      mem_addr            <= 20'h00000;
      chip_select_n       <= 1'b1;
      chip_select_hi      <= 1'b0;
      write_strobe_n      <= 1'b1;
      output_gate_n       <= 1'b1;
      upper_lane_enable_n <= 1'b1;
      lower_lane_enable_n <= 1'b1;
      data_bus_out        <= 16'h0000;
      data_bus_oe         <= 1'b0;
      rsp_rdata           <= 16'h0000;
      rsp_valid           <= 1'b0;
      req_ready           <= 1'b0;
    end else if (ce) begin
      state               <= next_state;
      cnt                 <= next_cnt;
      mem_addr            <= next_mem_addr;
      chip_select_n       <= next_cs_n;
      chip_select_hi      <= next_cs_hi;
      write_strobe_n      <= next_we_n;
      output_gate_n       <= next_oe_n;
      upper_lane_enable_n <= next_ub_n;
      lower_lane_enable_n <= next_lb_n;
      data_bus_out        <= next_dout;
      data_bus_oe         <= next_doe;
      rsp_rdata           <= next_rdata;
      rsp_valid           <= next_rsp;
      req_ready           <= next_ready;
    end
  end

  // Counts how long the output gate has stood open, for the read cycle check.
  localparam logic [psh_pkg::CNT_W-1:0] READ_MIN = psh_pkg::CNT_W'(psh_pkg::READ_CYC);
  logic [psh_pkg::CNT_W-1:0]  gate_low_cnt, next_gate_low_cnt;

  // Next value of the open-gate counter.
  always_comb begin
    next_gate_low_cnt = output_gate_n ? 5'h00 : gate_low_cnt + 5'h01;
  end

  // Registers the open-gate counter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gate_low_cnt <= 5'h00;
    end else if (ce) begin
      gate_low_cnt <= next_gate_low_cnt;
    end
  end

  // The host never drives the bus while the gate is open.
  a_no_bus_fight: assert property (@(posedge clk) disable iff (!resetn)
    !(data_bus_oe && !output_gate_n)) else $error("host drives bus while gate open");
  // Write data is driven the whole write interval.
  a_wdata_setup: assert property (@(posedge clk) disable iff (!resetn)
    (!write_strobe_n && !chip_select_n) |-> data_bus_oe) else $error("write data missing");
  // Write pulse lasts at least its least width.
  a_wpulse_width: assert property (@(posedge clk) disable iff (!resetn || !ce)
    $fell(write_strobe_n) |-> !write_strobe_n [*7]) else $error("write pulse too short");
  // Address holds steady while selected.
  a_addr_stable: assert property (@(posedge clk) disable iff (!resetn)
    (!chip_select_n && !$past(chip_select_n)) |-> $stable(mem_addr)) else $error("address moved");
  // Read strobe stays open for the whole read cycle.
  a_read_cycle: assert property (@(posedge clk) disable iff (!resetn || !ce)
    $rose(output_gate_n) |-> gate_low_cnt >= READ_MIN) else $error("read cycle too short");
  // Select and strobe end in the same cycle.
  a_end_together: assert property (@(posedge clk) disable iff (!resetn)
    $rose(write_strobe_n) |-> $rose(chip_select_n)) else $error("write end not joint");
  // At least one lane is enabled whenever selected.
  a_lane_enabled: assert property (@(posedge clk) disable iff (!resetn)
    !chip_select_n |-> !(upper_lane_enable_n && lower_lane_enable_n)) else $error("no lane");
  // Both selects move together.
  a_select_pair: assert property (@(posedge clk) disable iff (!resetn)
    chip_select_n == !chip_select_hi) else $error("selects disagree");
  // A read completes with a response exactly 13 cycles after the gate opens.
  a_read_answer: assert property (@(posedge clk) disable iff (!resetn || !ce)
    $fell(output_gate_n) |-> ##13 rsp_valid) else $error("read answer late");
endmodule // psh_host
`default_nettype wire

// file: pkg/psh_pkg.sv
`default_nettype none
package psh_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_PS = 8000;
  // Timing figures in nanoseconds.
  localparam int READ_CYCLE_MIN_NS = 70;
  localparam int ADDR_TO_DATA_MAX_NS = 70;
  localparam int GATE_TO_DATA_MAX_NS = 35;
  localparam int RELEASE_MAX_NS = 25;
  localparam int WRITE_CYCLE_MIN_NS = 70;
  localparam int WRITE_PULSE_MIN_NS = 55;
  localparam int WRITE_DATA_SETUP_NS = 25;
  localparam int WRITE_DATA_HOLD_NS = 0;
  localparam int ADDR_SETUP_TO_WRITE_START_NS = 0;
  localparam int ADDR_HOLD_AFTER_WRITE_NS = 0;
  // Least times round up to whole cycles, never below one.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  // Read strobe held long enough for both the cycle and address-to-data figures.
  localparam int READ_CYC = cyc_min(READ_CYCLE_MIN_NS);
  localparam int SAMPLE_CYC = cyc_min(ADDR_TO_DATA_MAX_NS);
  localparam int WPULSE_CYC = cyc_min(WRITE_PULSE_MIN_NS);
  localparam int WCYC = cyc_min(WRITE_CYCLE_MIN_NS);
  localparam int TURN_CYC = cyc_min(RELEASE_MAX_NS);
  localparam int CNT_W = 5;
endpackage
`default_nettype wire
